// ---- shared/mit_pkg.sv ----
// Constants, types and register map of the miscellaneous instruction and interval timer block
// Function
// RULE_01: Stack update loads stack pointer from memory
// RULE_02: Add signed byte operand, write sum back
// RULE_03: Condition set positive, negative or zero
// RULE_04: Overflow is carry-in xor carry-out, bit 23
// RULE_05: Block external interrupts one instruction after
// RULE_06: Execute memory word as if at own address
// RULE_07: Second word follows the execute instruction
// RULE_08: Block all interrupts one instruction after
// RULE_09: Program counter not advanced by execute
// RULE_10: Byte query ANDs low byte, sets condition
// RULE_11: Switch query ANDs switches, positive or zero
// RULE_12: Zero extend clears upper sixteen accumulator bits
// RULE_13: Hold stops timer until a release
// RULE_14: Release clock time starts the timer
// RULE_15: Processor mode pauses during channel cycles, interrupts
// RULE_16: Timer runs until held or halted
// RULE_17: Each microsecond decrement count, then test zero
// RULE_18: Zero count raises executive interrupt, keeps running
package mit_pkg;
  localparam int WORD_W = 24;
  localparam int ADDR_W = 12;
  localparam int NUM_EV = 3;
  // ***********************************************************
  // Register map (byte offsets)
  // ***********************************************************
  localparam logic [ADDR_W-1:0] REG_CMD = 12'h000;
  localparam logic [ADDR_W-1:0] REG_EA = 12'h004;
  localparam logic [ADDR_W-1:0] REG_ACC = 12'h008;
  localparam logic [ADDR_W-1:0] REG_COND = 12'h00C;
  localparam logic [ADDR_W-1:0] REG_SP = 12'h010;
  localparam logic [ADDR_W-1:0] REG_TIMER = 12'h014;
  localparam logic [ADDR_W-1:0] REG_STAT = 12'h018;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 12'h01C;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 12'h020;
  localparam logic [ADDR_W-1:0] REG_OWN_ADDR = 12'h024;
  // Command word fields
  localparam int CMD_OPC_LSB = 16;
  localparam int CMD_OPC_W = 4;
  localparam int OPND_W = 8;
  // Condition bits
  localparam int COND_OVF = 0;
  localparam int COND_NEG = 1;
  localparam int COND_ZERO = 2;
  localparam int COND_POS = 3;
  // Event bits
  localparam int EV_TIMER = 0;
  localparam int EV_DONE = 1;
  localparam int EV_OVF = 2;
  // Switch field of the query operand
  localparam int SW_LSB = 1;
  localparam int SW_W = 4;
  localparam int BYTE_W = 8;
  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMER_STEP_NS = 1000;
  localparam int TICK_CYCLES = TIMER_STEP_NS / CLK_PERIOD_NS;
  localparam int PRE_W = 7;
  // ***********************************************************
  // Types
  // ***********************************************************
  typedef enum logic [3:0] {
    MIT_OP_NONE = 4'h0, MIT_OP_STACK_UPDATE = 4'h1, MIT_OP_EXEC_MEM = 4'h2,
    MIT_OP_QUERY_BYTE = 4'h3, MIT_OP_QUERY_SW = 4'h4, MIT_OP_ZERO_EXT = 4'h5,
    MIT_OP_HOLD_TIMER = 4'h6, MIT_OP_REL_CLOCK = 4'h7, MIT_OP_REL_PROC = 4'h8
  } mit_op_t;
  typedef enum logic [2:0] {
    MIT_IDLE = 3'b001, MIT_READ = 3'b010, MIT_WRITE = 3'b100
  } mit_state_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [WORD_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } mit_mem_req_t;
  typedef struct packed {
    logic ack;
    logic [WORD_W-1:0] rdata;
  } mit_mem_rsp_t;
  typedef struct packed {
    logic valid;
    logic hold_pc;
    logic [WORD_W-1:0] word;
    logic [WORD_W-1:0] pc;
    logic [WORD_W-1:0] word2_addr;
  } mit_exec_t;
endpackage : mit_pkg

// ---- rtl/mit_core.sv ----
// Miscellaneous instruction execution and interval timer with APB register access
`timescale 1ns/100ps
`default_nettype none
module mit_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mit_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output mit_pkg::mit_mem_req_t mem_req,
  input wire mit_pkg::mit_mem_rsp_t mem_rsp,
  output mit_pkg::mit_exec_t exec_out,
  input wire logic [mit_pkg::SW_W-1:0] sense_switch,
  input wire logic io_block_cycle,
  input wire logic int_active,
  input wire logic cpu_halted,
  input wire logic instr_done,
  output logic ext_int_block,
  output logic all_int_block,
  output logic exec_int,
  output logic irq
);
  import mit_pkg::*;

  // ***********************************************************
  // State
  // ***********************************************************
  typedef struct packed {
    mit_state_t st;
    mit_op_t op;
    logic [OPND_W-1:0] opnd;
    logic [WORD_W-1:0] ea;
    logic [WORD_W-1:0] own;
    logic [WORD_W-1:0] acc;
    logic [3:0] cond;
    logic [WORD_W-1:0] sp;
    logic [WORD_W-1:0] tcount;
    logic [PRE_W-1:0] pre;
    logic running;
    logic proc_mode;
    logic ext_blk;
    logic all_blk;
    logic [NUM_EV-1:0] ev_stat;
    logic [NUM_EV-1:0] ev_mask;
    logic irq;
    logic exec_int;
    mit_mem_req_t mreq;
    mit_exec_t ex;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } mit_regs_t;

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
  localparam logic [WORD_W-1:0] WORD_ONE = 24'h000001;
  localparam logic [WORD_W-1:0] WORD_ZERO = 24'h000000;

  mit_regs_t r;
  mit_regs_t next_r;

  // ***********************************************************
  // Read decode
  // ***********************************************************
  logic [31:0] rd_val;
  logic rd_hit;

  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      REG_CMD: rd_val = 32'h0000_0000;
      REG_EA: rd_val = {8'h00, r.ea};
      REG_ACC: rd_val = {8'h00, r.acc};
      REG_COND: rd_val = {28'h000_0000, r.cond};
      REG_SP: rd_val = {8'h00, r.sp};
      REG_TIMER: rd_val = {8'h00, r.tcount};
      REG_STAT: rd_val = {27'h000_0000, r.all_blk, r.ext_blk, r.proc_mode, r.running,
                          (r.st != MIT_IDLE)};
      REG_IRQ_STAT: rd_val = {29'h0000_0000, r.ev_stat};
      REG_IRQ_MASK: rd_val = {29'h0000_0000, r.ev_mask};
      REG_OWN_ADDR: rd_val = {8'h00, r.own};
      default: rd_hit = 1'b0;
    endcase
  end

  // ***********************************************************
  // Stack update arithmetic
  // ***********************************************************
  logic [WORD_W-1:0] opnd_ext;
  logic [WORD_W:0] sum_full;
  logic [WORD_W-1:0] sum_low;
  logic carry_in;
  logic carry_out;

  always_comb
  begin
    // RULE_02 sign-extended operand
    opnd_ext = {{(WORD_W-OPND_W){r.opnd[OPND_W-1]}}, r.opnd};
    sum_full = {1'b0, mem_rsp.rdata} + {1'b0, opnd_ext};
    sum_low = {1'b0, mem_rsp.rdata[WORD_W-2:0]} + {1'b0, opnd_ext[WORD_W-2:0]};
    carry_in = sum_low[WORD_W-1];
    carry_out = sum_full[WORD_W];
  end

  // Sets exactly one of positive, negative or zero from a signed value
  function automatic logic [3:0] sign_cond(input logic neg, input logic nz);
    logic [3:0] c;
    c = 4'h0;
    c[COND_NEG] = neg;
    c[COND_ZERO] = !nz;
    c[COND_POS] = !neg && nz;
    return c;
  endfunction : sign_cond

  // ***********************************************************
  // Next state
  // ***********************************************************
  logic apb_wr;
  logic [NUM_EV-1:0] ev;
  logic [WORD_W-1:0] tdec;
  logic [BYTE_W-1:0] byte_and;
  logic [SW_W-1:0] sw_and;
  mit_op_t new_op;

  always_comb
  begin
    next_r = r;
    ev = '0;
    tdec = r.tcount - WORD_ONE;
    byte_and = pwdata[BYTE_W-1:0] & r.acc[BYTE_W-1:0];
    sw_and = pwdata[SW_LSB +: SW_W] & sense_switch;
    new_op = mit_op_t'(pwdata[CMD_OPC_LSB +: CMD_OPC_W]);
    next_r.exec_int = 1'b0;
    next_r.ex.valid = 1'b0;
    next_r.pready = 1'b0;
    apb_wr = psel && penable && r.pready && pwrite;

    // APB: one wait cycle so that all answer signals are registered
    // Cost: every access, even a plain read, takes two access cycles
    if (psel && penable && !r.pready)
    begin
      next_r.pready = 1'b1;
      next_r.prdata = pwrite ? 32'h0000_0000 : rd_val;
      // Busy engine refuses a new command
      next_r.pslverr = !rd_hit || (pwrite && paddr == REG_CMD && r.st != MIT_IDLE);
    end

    // Interrupt-block window ends at the next instruction boundary
    if (instr_done)
    begin
      next_r.ext_blk = 1'b0;
      next_r.all_blk = 1'b0;
    end

    // ***********************************************************
    // Interval timer
    // ***********************************************************
    // RULE_16 halt stops the timer
    if (cpu_halted)
    begin
      next_r.running = 1'b0;
    end
    // RULE_15 processor-time mode pauses on channel cycles and interrupts
    else if (r.running && !(r.proc_mode && (io_block_cycle || int_active)))
    begin
      if (r.pre == PRE_LAST)
      begin
        next_r.pre = '0;
        // RULE_17 decrement, then test the new count
        next_r.tcount = tdec;
        // RULE_18 executive interrupt, timer keeps running
        if (tdec == WORD_ZERO)
        begin
          next_r.exec_int = 1'b1;
          ev[EV_TIMER] = 1'b1;
        end
      end
      else
      begin
        next_r.pre = r.pre + 1'b1;
      end
    end

    // ***********************************************************
    // Memory sequencing
    // ***********************************************************
    case (r.st)
      MIT_IDLE:
      begin
        next_r.mreq.req = 1'b0;
      end
      // Request stays up until acknowledged; a lost acknowledge leaves the engine busy
      MIT_READ:
      begin
        if (mem_rsp.ack)
        begin
          if (r.op == MIT_OP_STACK_UPDATE)
          begin
            // RULE_01 stack pointer from the addressed word
            next_r.sp = mem_rsp.rdata;
            // RULE_02 write sum back to the same address
            next_r.mreq.we = 1'b1;
            next_r.mreq.wdata = sum_full[WORD_W-1:0];
            // RULE_03 one of positive, negative, zero
            next_r.cond = sign_cond(sum_full[WORD_W-1], sum_full[WORD_W-1:0] != WORD_ZERO);
            // RULE_04 overflow from sign-bit carries
            next_r.cond[COND_OVF] = carry_in ^ carry_out;
            ev[EV_OVF] = carry_in ^ carry_out;
            next_r.st = MIT_WRITE;
          end
          else
          begin
            // RULE_06 hand the word over as if fetched at our own address
            next_r.ex.valid = 1'b1;
            next_r.ex.word = mem_rsp.rdata;
            next_r.ex.pc = r.own;
            // RULE_07 a second word comes from the next location
            next_r.ex.word2_addr = r.own + WORD_ONE;
            // RULE_09 program counter stays put
            next_r.ex.hold_pc = 1'b1;
            // RULE_08 all interrupts blocked for one instruction
            next_r.all_blk = 1'b1;
            next_r.mreq.req = 1'b0;
            ev[EV_DONE] = 1'b1;
            next_r.st = MIT_IDLE;
          end
        end
      end
      MIT_WRITE:
      begin
        if (mem_rsp.ack)
        begin
          next_r.mreq.req = 1'b0;
          next_r.mreq.we = 1'b0;
          // RULE_05 external interrupts blocked for one instruction
          next_r.ext_blk = 1'b1;
          ev[EV_DONE] = 1'b1;
          next_r.st = MIT_IDLE;
        end
      end
      default:
      begin
        next_r.st = MIT_IDLE;
        next_r.mreq.req = 1'b0;
      end
    endcase

    // ***********************************************************
    // Register writes, taken at the edge where pready is sampled
    // ***********************************************************
    if (apb_wr)
    begin
      case (paddr)
        REG_EA: next_r.ea = pwdata[WORD_W-1:0];
        REG_ACC: next_r.acc = pwdata[WORD_W-1:0];
        // A software write overrides a decrement in the same cycle
        REG_TIMER: next_r.tcount = pwdata[WORD_W-1:0];
        REG_IRQ_MASK: next_r.ev_mask = pwdata[NUM_EV-1:0];
        REG_OWN_ADDR: next_r.own = pwdata[WORD_W-1:0];
        // Sticky status: software clears a bit by writing a one to it
        REG_IRQ_STAT: next_r.ev_stat = r.ev_stat & ~pwdata[NUM_EV-1:0];
        REG_CMD:
        begin
          // An access already answered with an error must not start a command
          if (r.st == MIT_IDLE && !r.pslverr)
          begin
            next_r.op = new_op;
            next_r.opnd = pwdata[OPND_W-1:0];
            case (new_op)
              MIT_OP_STACK_UPDATE, MIT_OP_EXEC_MEM:
              begin
                next_r.mreq.req = 1'b1;
                next_r.mreq.we = 1'b0;
                next_r.mreq.addr = r.ea;
                next_r.st = MIT_READ;
              end
              MIT_OP_QUERY_BYTE:
              begin
                // RULE_10 result only sets the condition
                next_r.cond = sign_cond(byte_and[BYTE_W-1], byte_and != 8'h00);
                ev[EV_DONE] = 1'b1;
              end
              MIT_OP_QUERY_SW:
              begin
                // RULE_11 positive or zero only
                next_r.cond = sign_cond(1'b0, sw_and != 4'h0);
                ev[EV_DONE] = 1'b1;
              end
              MIT_OP_ZERO_EXT:
              begin
                // RULE_12 upper bits cleared, condition untouched
                next_r.acc = {{(WORD_W-BYTE_W){1'b0}}, r.acc[BYTE_W-1:0]};
                ev[EV_DONE] = 1'b1;
              end
              MIT_OP_HOLD_TIMER:
              begin
                // RULE_13 stopped until a release
                next_r.running = 1'b0;
                ev[EV_DONE] = 1'b1;
              end
              MIT_OP_REL_CLOCK, MIT_OP_REL_PROC:
              begin
                // RULE_14 start counting; release picks the mode
                // A release while halted leaves the timer stopped; it must be issued again
                next_r.running = !cpu_halted;
                next_r.proc_mode = (new_op == MIT_OP_REL_PROC);
                // Prescaler restarts so the first step is a whole microsecond
                next_r.pre = '0;
                ev[EV_DONE] = 1'b1;
              end
              default:
              begin
                next_r.op = MIT_OP_NONE;
              end
            endcase
          end
        end
        default:
        begin
          next_r.ev_stat = next_r.ev_stat;
        end
      endcase
    end

    // A new event wins over a simultaneous write-one-to-clear
    next_r.ev_stat = next_r.ev_stat | ev;
    next_r.irq = |(next_r.ev_stat & next_r.ev_mask);
  end

  // ***********************************************************
  // Registers
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      // Idle and no-op codes are set by name, not left to the all-zero clear
      r.st <= MIT_IDLE;
      r.op <= MIT_OP_NONE;
    end
    else if (ce)
    begin
      r <= next_r;
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  // Every output is a register copy, so no decode glitch reaches a pin
  assign pready = r.pready;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign mem_req = r.mreq;
  assign exec_out = r.ex;
  assign ext_int_block = r.ext_blk;
  assign all_int_block = r.all_blk;
  assign exec_int = r.exec_int;
  assign irq = r.irq;
endmodule : mit_core
`default_nettype wire

// ---- verif/mit_core_properties.sv ----
// Concurrent checks on the miscellaneous instruction block ports
`timescale 1ns/100ps
`default_nettype none
module mit_core_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic cpu_halted,
  input wire logic instr_done,
  input wire mit_pkg::mit_mem_req_t mem_req,
  input wire mit_pkg::mit_mem_rsp_t mem_rsp,
  input wire mit_pkg::mit_exec_t exec_out,
  input wire logic ext_int_block,
  input wire logic all_int_block,
  input wire logic exec_int
);
  import mit_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr_ack;
    mem_req.req && mem_req.we && mem_rsp.ack;
  endsequence
  property p_apb_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer late");
  property p_req_hold;
    mem_req.req && !mem_rsp.ack |=> mem_req.req && $stable(mem_req.addr) && $stable(mem_req.we);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("memory request dropped");
  property p_stack_blk;
    s_wr_ack |=> ext_int_block && !mem_req.req;
  endproperty
  a_stack_blk: assert property (p_stack_blk) else $error("no external block");
  property p_ext_clr;
    ext_int_block && instr_done && !mem_rsp.ack |=> !ext_int_block;
  endproperty
  a_ext_clr: assert property (p_ext_clr) else $error("external block stuck");
  property p_exec_pc;
    exec_out.valid |-> exec_out.hold_pc && exec_out.word2_addr == exec_out.pc + 24'h000001;
  endproperty
  a_exec_pc: assert property (p_exec_pc) else $error("execute pc wrong");
  property p_exec_blk;
    exec_out.valid |-> all_int_block;
  endproperty
  a_exec_blk: assert property (p_exec_blk) else $error("no full block");
  property p_all_clr;
    all_int_block && instr_done && !mem_rsp.ack |=> !all_int_block;
  endproperty
  a_all_clr: assert property (p_all_clr) else $error("full block stuck");
  property p_exec_pulse;
    exec_out.valid |=> !exec_out.valid;
  endproperty
  a_exec_pulse: assert property (p_exec_pulse) else $error("execute twice");
  property p_halt;
    cpu_halted [*3] |=> !exec_int;
  endproperty
  a_halt: assert property (p_halt) else $error("timer runs halted");
  property p_tick_gap;
    exec_int |=> !exec_int [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("zero too often");
endmodule : mit_core_properties
bind mit_core mit_core_properties i_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .cpu_halted(cpu_halted),
  .instr_done(instr_done),
  .mem_req(mem_req),
  .mem_rsp(mem_rsp),
  .exec_out(exec_out),
  .ext_int_block(ext_int_block),
  .all_int_block(all_int_block),
  .exec_int(exec_int)
);
`default_nettype wire

// ---- verif/mit_mem_model.sv ----
// Processor memory model behind the block's memory port
`timescale 1ns/100ps
`default_nettype none
module mit_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] lat,
  input wire mit_pkg::mit_mem_req_t mem_req,
  output mit_pkg::mit_mem_rsp_t mem_rsp
);
  import mit_pkg::*;
  logic [WORD_W-1:0] mem [0:255];
  logic [1:0] waited;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_rsp <= '0;
      waited <= 2'h0;
    end
    else
    begin
      mem_rsp.ack <= 1'h0;
      // Idle data toggles so a stale read never matches
      mem_rsp.rdata <= ~mem_rsp.rdata;
      if (mem_req.req && !mem_rsp.ack && waited < lat)
        waited <= waited + 2'h1;
      else if (mem_req.req && !mem_rsp.ack)
      begin
        waited <= 2'h0;
        mem_rsp.ack <= 1'h1;
        if (mem_req.we)
          mem[mem_req.addr[7:0]] <= mem_req.wdata;
        else
          mem_rsp.rdata <= mem[mem_req.addr[7:0]];
      end
    end
  end
endmodule : mit_mem_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the miscellaneous instruction block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import mit_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  mit_mem_req_t mem_req;
  mit_mem_rsp_t mem_rsp;
  mit_exec_t exec_out;
  logic [SW_W-1:0] sense_switch = '0;
  logic io_block_cycle = 1'h0;
  logic int_active = 1'h0;
  logic cpu_halted = 1'h0;
  logic instr_done = 1'h0;
  logic ce = 1'h1;
  logic ext_int_block;
  logic all_int_block;
  logic exec_int;
  logic irq;
  logic [1:0] lat = 2'h0;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int t0;
  integer seed = 32'hBB983298;
  logic [31:0] rd;
  logic [31:0] v;
  logic [31:0] x;
  logic er;
  logic [23:0] a;
  logic [23:0] s;
  logic [7:0] b;
  logic [23:0] ta [3] = '{24'h7FFFFF, 24'h800000, 24'h000005};
  logic [7:0] tb_op [3] = '{8'h01, 8'hFF, 8'hFB};
  always #5 pclk = ~pclk;
  mit_core i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .mem_req(mem_req),
    .mem_rsp(mem_rsp),
    .exec_out(exec_out),
    .sense_switch(sense_switch),
    .io_block_cycle(io_block_cycle),
    .int_active(int_active),
    .cpu_halted(cpu_halted),
    .instr_done(instr_done),
    .ext_int_block(ext_int_block),
    .all_int_block(all_int_block),
    .exec_int(exec_int),
    .irq(irq)
  );
  mit_mem_model i_mem (
    .pclk(pclk),
    .presetn(presetn),
    .lat(lat),
    .mem_req(mem_req),
    .mem_rsp(mem_rsp)
  );
  // ****
  // Tasks
  // ****
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic pulse_done();
    @(posedge pclk);
    instr_done <= 1'h1;
    @(posedge pclk);
    instr_done <= 1'h0;
    @(posedge pclk);
  endtask : pulse_done
  function automatic logic [31:0] cmd(input logic [3:0] op, input logic [7:0] o);
    return {12'h000, op, 8'h00, o};
  endfunction : cmd
  function automatic logic [31:0] cond(input logic [23:0] r, input logic n, input logic ov);
    return {28'h0000000, r != 0 && !n, r == 0, n, ov};
  endfunction : cond
  // Hang guard well above the expected run length
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      conclude();
    end
  end
  // ****
  // Sequence
  // ****
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 12'h028, 32'h0);
    chk(er, 1'h1);
    for (int k = 12; k <= 32; k += 4)
    begin
      apb(1'h0, 12'(k), 32'h0);
      chk(rd, 32'h0);
    end
    $display("test reset done");
    for (int i = 0; i < 5; i++)
    begin
      v = $random(seed);
      a = i < 3 ? ta[i] : v[23:0];
      b = i < 3 ? tb_op[i] : v[31:24];
      lat <= i == 0 ? 2'h3 : v[1:0];
      i_mem.mem[i] = a;
      apb(1'h1, REG_EA, 32'(i));
      apb(1'h1, REG_CMD, cmd(4'h1, b));
      if (i == 0)
      begin
        apb(1'h1, REG_CMD, cmd(4'h5, 8'h00));
        chk(er, 1'h1);
      end
      while (ext_int_block !== 1'h1)
        @(posedge pclk);
      s = a + {{16{b[7]}}, b};
      chk(i_mem.mem[i], s);
      apb(1'h0, REG_SP, 32'h0);
      chk(rd, a);
      apb(1'h0, REG_COND, 32'h0);
      chk(rd, cond(s, s[23], a[23] == b[7] && s[23] != a[23]));
      pulse_done();
      chk(ext_int_block, 1'h0);
    end
    $display("test stack update done");
    i_mem.mem[9] = 24'hA5C3E1;
    apb(1'h1, REG_OWN_ADDR, 32'h123);
    apb(1'h1, REG_EA, 32'h9);
    apb(1'h1, REG_CMD, cmd(4'h2, 8'h00));
    while (exec_out.valid !== 1'h1)
      @(posedge pclk);
    chk(exec_out.word, 24'hA5C3E1);
    chk(exec_out.pc, 24'h000123);
    chk(exec_out.word2_addr, 24'h000124);
    chk(exec_out.hold_pc, 1'h1);
    chk(all_int_block, 1'h1);
    pulse_done();
    chk(all_int_block, 1'h0);
    $display("test execute done");
    for (int i = 0; i < 4; i++)
    begin
      v = $random(seed);
      sense_switch <= v[11:8];
      apb(1'h1, REG_ACC, v & 32'hFFFFFF);
      apb(1'h1, REG_CMD, cmd(4'h3, v[31:24]));
      apb(1'h0, REG_COND, 32'h0);
      b = v[7:0] & v[31:24];
      chk(rd, cond({16'h0000, b}, b[7], 1'h0));
      apb(1'h1, REG_CMD, cmd(4'h4, v[31:24]));
      apb(1'h0, REG_COND, 32'h0);
      x = cond({20'h00000, v[28:25] & v[11:8]}, 1'h0, 1'h0);
      chk(rd, x);
      apb(1'h1, REG_CMD, cmd(4'h5, 8'h00));
      apb(1'h0, REG_ACC, 32'h0);
      chk(rd, {24'h000000, v[7:0]});
      apb(1'h0, REG_COND, 32'h0);
      chk(rd, x);
    end
    $display("test queries done");
    apb(1'h1, REG_TIMER, 32'h3);
    apb(1'h1, REG_IRQ_MASK, 32'h1);
    apb(1'h1, REG_CMD, cmd(4'h7, 8'h00));
    t0 = cyc;
    while (exec_int !== 1'h1)
      @(posedge pclk);
    chk((cyc - t0) inside {[298:304]}, 1'h1);
    apb(1'h0, REG_TIMER, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, REG_STAT, 32'h0);
    chk(rd[1], 1'h1);
    chk(irq, 1'h1);
    apb(1'h1, REG_IRQ_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'h0);
    apb(1'h0, REG_TIMER, 32'h0);
    x = rd;
    ce <= 1'h0;
    repeat (250) @(posedge pclk);
    ce <= 1'h1;
    apb(1'h0, REG_TIMER, 32'h0);
    chk(x - rd < 32'h2, 1'h1);
    apb(1'h1, REG_CMD, cmd(4'h6, 8'h00));
    apb(1'h0, REG_TIMER, 32'h0);
    x = rd;
    repeat (250) @(posedge pclk);
    apb(1'h0, REG_TIMER, 32'h0);
    chk(rd, x);
    $display("test timer done");
    apb(1'h1, REG_CMD, cmd(4'h8, 8'h00));
    for (int k = 0; k < 3; k++)
    begin
      {cpu_halted, io_block_cycle, int_active} <= 3'h1 << k;
      repeat (4) @(posedge pclk);
      apb(1'h0, REG_TIMER, 32'h0);
      x = rd;
      repeat (250) @(posedge pclk);
      apb(1'h0, REG_TIMER, 32'h0);
      chk(rd, x);
      {cpu_halted, io_block_cycle, int_active} <= 3'h0;
      if (k < 2)
      begin
        repeat (250) @(posedge pclk);
        apb(1'h0, REG_TIMER, 32'h0);
        chk(rd != x, 1'h1);
      end
    end
    $display("test timer modes done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
